/* File: umd_pkg.sv */
package umd_pkg;
    // Register offsets of the device (byte addresses, one word each)
    localparam logic [3:0] OFS_CTRL_A   = 4'h0;
    localparam logic [3:0] OFS_CTRL_B   = 4'h4;
    localparam logic [3:0] OFS_DATA     = 4'h8;
    localparam logic [3:0] OFS_IRQ_STAT = 4'hC;

    // Bit positions in serial_ctrl_status_a
    localparam int BIT_RXC  = 0;
    localparam int BIT_TXC  = 1;
    localparam int BIT_FE   = 2;
    localparam int BIT_PE   = 3;
    localparam int BIT_OVR  = 4;
    localparam int BIT_AFM  = 5;
    localparam int BIT_DSP  = 6;
    localparam int BIT_RX9  = 7;
    localparam int BIT_TX9  = 8;

    // Bit positions in the control word b
    localparam int BIT_SZ_LO  = 0;
    localparam int BIT_TWOSTP = 3;
    localparam int BIT_PAREN  = 4;
    localparam int BIT_PARODD = 5;
    localparam int BIT_DIV_LO = 16;

    // Character size code that selects nine-bit frames
    localparam logic [2:0] SZ_NINE = 3'h7;
    localparam int NUM_EVT = 3;

    // Oversampling and majority-vote sample positions
    localparam logic [3:0] OVS_NORM  = 4'hF;  // 16 samples, last index
    localparam logic [3:0] OVS_DBL   = 4'h7;  // 8 samples, last index
    localparam logic [3:0] FIRST_NRM = 4'h8;
    localparam logic [3:0] MID_NRM   = 4'h9;
    localparam logic [3:0] LAST_NRM  = 4'hA;
    localparam logic [3:0] FIRST_DBL = 4'h4;
    localparam logic [3:0] MID_DBL   = 4'h5;
    localparam logic [3:0] LAST_DBL  = 4'h6;

    // Receiver states, Gray coded along the usual path from RX_IDLE to RX_DONE; RX_DONE back to RX_IDLE flips two bits
    typedef enum logic [2:0] {
        RX_IDLE  = 3'b000,
        RX_START = 3'b001,
        RX_BITS  = 3'b011,
        RX_STOP  = 3'b010,
        RX_DONE  = 3'b110
    } umd_rx_state_t;

    // Transmitter states
    typedef enum logic [1:0] {
        TX_IDLE  = 2'b00,
        TX_SHIFT = 2'b01,
        TX_END   = 2'b11
    } umd_tx_state_t;
endpackage : umd_pkg

/* File: umd_line_if.sv */
`timescale 1ns/100ps
// Shared serial line between the master transmitter and the slave receiver
interface umd_line_if;
    logic m2s_line;  // Master to slave, idle high
    logic s2m_line;  // Slave to master, idle high

    modport master (output m2s_line, input s2m_line);
    modport slave  (input m2s_line, output s2m_line);
endinterface : umd_line_if

/* File: umd_oversampler.sv */
`timescale 1ns/100ps
// Sample-rate enable and majority vote over the three centre samples
module umd_oversampler
    import umd_pkg::*;
#(
    parameter int DIV_W = 12
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [DIV_W-1:0] divisor_i,
    input  wire logic             dbl_i,
    input  wire logic             line_i,
    input  wire logic             restart_i,
    output logic                  tick_o,
    output logic                  bit_end_o,
    output logic                  vote_o,
    output logic                  vote_valid_o
);
    logic [DIV_W-1:0] div_reg;
    logic [3:0]       smp_reg;
    logic [2:0]       win_reg;

    wire logic [3:0] last_idx = dbl_i ? OVS_DBL : OVS_NORM;        // see R1
    wire logic [3:0] first_s  = dbl_i ? FIRST_DBL : FIRST_NRM;     // see R2
    wire logic [3:0] mid_s    = dbl_i ? MID_DBL : MID_NRM;         // see R3
    wire logic [3:0] last_s   = dbl_i ? LAST_DBL : LAST_NRM;
    wire logic       tick     = (div_reg == '0);
    wire logic [3:0] smp_num  = smp_reg + 4'h1;                    // Samples counted from one
    wire logic       in_win   = (smp_num == first_s) || (smp_num == mid_s) || (smp_num == last_s);

    // Sample-rate divider and sample counter, restarted on a start edge
    always_ff @(posedge clk_i) begin
        if (rst_i || restart_i) begin
            div_reg <= divisor_i;
            smp_reg <= '0;
        end else if (tick) begin
            div_reg <= divisor_i;
            smp_reg <= (smp_reg == last_idx) ? 4'h0 : smp_reg + 4'h1;
        end else begin
            div_reg <= div_reg - DIV_W'(1);
        end
    end

    // Three-sample window shift register
    always_ff @(posedge clk_i) begin
        if (rst_i || restart_i) begin
            win_reg <= '0;
        end else if (tick && in_win) begin
            win_reg <= {win_reg[1:0], line_i};
        end
    end

    // Two of three wins; valid on the sample tick after the third sample
    assign vote_o       = (win_reg[0] & win_reg[1]) | (win_reg[0] & win_reg[2]) | (win_reg[1] & win_reg[2]); // see R17
    assign tick_o       = tick;
    assign vote_valid_o = tick && (smp_reg == last_s);                                      // see R4 see R5
    assign bit_end_o    = tick && (smp_reg == last_idx);
endmodule : umd_oversampler

/* File: umd_master_end.sv */
`timescale 1ns/100ps
// Master transmitter: sends nine-bit frames, ninth bit marks an address
module umd_master_end
    import umd_pkg::*;
#(
    parameter int DIV_W = 12,
    parameter int NBITS = 9
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [DIV_W-1:0] divisor_i,
    input  wire logic             dbl_i,
    input  wire logic [7:0]       data_i,
    input  wire logic             is_addr_i,
    input  wire logic             send_i,
    output logic                  busy_o,
    output logic                  done_o,
    umd_line_if.master            line
);
    umd_tx_state_t    st_reg;
    logic [DIV_W-1:0] div_reg;
    logic [3:0]       smp_reg;
    logic [3:0]       cnt_reg;
    logic [NBITS+2:0] sh_reg;
    logic             line_reg;
    logic             busy_reg;
    logic             done_reg;

    wire logic       tick     = (div_reg == '0);                   // see R6
    wire logic [3:0] last_idx = dbl_i ? OVS_DBL : OVS_NORM;
    wire logic       bit_end  = tick && (smp_reg == last_idx);
    // Start, eight data bits, ninth bit high for an address, two stop bits
    wire logic [NBITS+2:0] frame = {2'b11, is_addr_i, data_i, 1'b0}; // see R12 see R14

    // Frame shifter paced by its own sample divider, built like the receiver's
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg <= TX_IDLE; div_reg <= '0; smp_reg <= '0; cnt_reg <= '0;
            sh_reg <= '1; line_reg <= 1'b1; busy_reg <= 1'b0; done_reg <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            div_reg  <= tick ? divisor_i : div_reg - DIV_W'(1);
            if (tick) smp_reg <= (smp_reg == last_idx) ? 4'h0 : smp_reg + 4'h1;
            case (st_reg)
                TX_IDLE: begin
                    if (send_i) begin
                        sh_reg   <= frame;
                        line_reg <= 1'b0;
                        cnt_reg  <= 4'(NBITS + 2);
                        div_reg  <= divisor_i;
                        smp_reg  <= '0;
                        busy_reg <= 1'b1;
                        st_reg   <= TX_SHIFT;
                    end
                end
                TX_SHIFT: begin
                    if (bit_end) begin
                        sh_reg   <= {1'b1, sh_reg[NBITS+2:1]};
                        line_reg <= sh_reg[1];
                        cnt_reg  <= cnt_reg - 4'h1;
                        if (cnt_reg == 4'h0) st_reg <= TX_END;
                    end
                end
                TX_END: begin
                    line_reg <= 1'b1;
                    busy_reg <= 1'b0;
                    done_reg <= 1'b1;
                    st_reg   <= TX_IDLE;
                end
                default: st_reg <= TX_IDLE;
            endcase
        end
    end

    assign line.m2s_line = line_reg;
    assign busy_o        = busy_reg;
    assign done_o        = done_reg;
endmodule : umd_master_end

/* File: umd_slave_end.sv */
`timescale 1ns/100ps
// Notes on behaviour
// R1: oversample 16 normal, 8 double speed
// R2: first vote sample 8 or 4
// R3: middle vote sample 9 or 5
// R4: accept slow data to 95.36/96.00 percent
// R5: accept fast data to 104.58/103.90 percent
// R6: each side keeps half the error
// R7: filter mode drops non-address frames
// R8: frame type: stop bit, or ninth bit
// R9: type one is address, zero data
// R10: transmitter ignores filter mode
// R11: address frames stored and flagged normally
// R12: master sends nine-bit frames, ninth marks address
// R13: software clears or sets filter mode
// R14: short frames need two stop bits
// R15: one character size for both directions
// R16: filter bit shares word with tx flag
// R17: majority vote each bit, first stop only
// R18: dropped frames change no status
module umd_slave_end
    import umd_pkg::*;
#(
    parameter int DIV_W = 12
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_we_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    output logic             irq_o,
    umd_line_if.slave        line
);
    umd_rx_state_t    rx_st_reg;
    umd_tx_state_t    tx_st_reg;
    logic [8:0]       ctrl_a_reg;
    logic [31:0]      ctrl_b_reg;
    logic [2:0]       irq_stat_reg;
    logic [2:0]       irq_mask_reg;
    logic [8:0]       rx_sh_reg;
    logic [3:0]       rx_cnt_reg;
    logic             rx_par_reg;
    logic [8:0]       rx_buf_reg;
    logic             buf_full_reg;
    logic             line_q_reg;
    logic [10:0]      tx_sh_reg;
    logic [3:0]       tx_cnt_reg;
    logic             tx_line_reg;
    logic             ack_reg;
    logic [31:0]      rdat_reg;
    logic             irq_reg;

    // Bus decode
    wire logic        acc     = wb_cyc_i && wb_stb_i && !ack_reg;
    wire logic        wr      = acc && wb_we_i && wb_sel_i[0];
    wire logic        rd      = acc && !wb_we_i;
    wire logic        hit_a   = (wb_adr_i == OFS_CTRL_A);
    wire logic        hit_b   = (wb_adr_i == OFS_CTRL_B);
    wire logic        hit_d   = (wb_adr_i == OFS_DATA);
    wire logic        hit_i   = (wb_adr_i == OFS_IRQ_STAT);
    wire logic        rd_data = rd && hit_d;
    wire logic        wr_data = wr && hit_d;

    // Configuration fields, all but afm shared by both directions
    wire logic [2:0]       sz      = ctrl_b_reg[BIT_SZ_LO +: 3];         // see R15
    wire logic             nine    = (sz == SZ_NINE);
    wire logic [3:0]       nbits   = nine ? 4'h9 : {1'b0, sz} + 4'h5;   // Data bits per frame
    wire logic             par_en  = ctrl_b_reg[BIT_PAREN];
    wire logic [DIV_W-1:0] divisor = ctrl_b_reg[BIT_DIV_LO +: DIV_W];
    wire logic             dbl     = ctrl_a_reg[BIT_DSP];
    wire logic             afm     = ctrl_a_reg[BIT_AFM];

    // Receiver sampling
    logic vote, vote_ok;
    wire logic restart = (rx_st_reg == RX_IDLE) && line_q_reg && !line.m2s_line;

    umd_oversampler #(.DIV_W(DIV_W)) u_ovs (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .divisor_i    (divisor),
        .dbl_i        (dbl),
        .line_i       (line.m2s_line),
        .restart_i    (restart),
        .tick_o       (),
        .bit_end_o    (),
        .vote_o       (vote),
        .vote_valid_o (vote_ok)
    );

    // Frame assembly; type bit is the ninth data bit or the first stop bit
    wire logic ftype    = nine ? rx_sh_reg[8] : vote;                    // see R8
    wire logic keep     = !afm || ftype;                                 // see R7 see R9
    wire logic par_bad  = par_en && (rx_par_reg ^ ctrl_b_reg[BIT_PARODD] ^ (^rx_sh_reg));
    wire logic stop_hit = (rx_st_reg == RX_STOP) && vote_ok;
    wire logic store    = stop_hit && keep;                              // see R11 see R18
    wire logic [8:0] rx_word = rx_sh_reg >> (4'h9 - nbits);

    // Receive state machine: start check, data, parity, one stop bit
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_st_reg  <= RX_IDLE;
            rx_sh_reg  <= '0;
            rx_cnt_reg <= '0;
            rx_par_reg <= 1'b0;
            line_q_reg <= 1'b1;
        end else begin
            line_q_reg <= line.m2s_line;
            case (rx_st_reg)
                RX_IDLE:  if (restart) rx_st_reg <= RX_START;
                RX_START: if (vote_ok) begin
                    rx_st_reg  <= vote ? RX_IDLE : RX_BITS;              // see R17
                    rx_cnt_reg <= nbits + {3'h0, par_en};
                end
                RX_BITS:  if (vote_ok) begin
                    if (par_en && rx_cnt_reg == 4'h1) rx_par_reg <= vote;
                    else rx_sh_reg <= {vote, rx_sh_reg[8:1]};
                    rx_cnt_reg <= rx_cnt_reg - 4'h1;
                    if (rx_cnt_reg == 4'h1) rx_st_reg <= RX_STOP;
                end
                RX_STOP:  if (vote_ok) rx_st_reg <= RX_DONE;             // see R17
                RX_DONE:  rx_st_reg <= RX_IDLE;                          // Next start may follow at once
                default:  rx_st_reg <= RX_IDLE;
            endcase
        end
    end

    // Transmitter, unaware of filter mode
    wire logic [3:0] tx_len = nbits + {3'h0, par_en} + {3'h0, ctrl_b_reg[BIT_TWOSTP]} + 4'h1; // see R10
    wire logic       tx_par = par_en & (ctrl_b_reg[BIT_PARODD] ^ (^ctrl_a_reg[BIT_TX9]) ^ 1'b0);
    wire logic [8:0] tx_word = nine ? {ctrl_a_reg[BIT_TX9], wb_dat_i[7:0]} : {1'b0, wb_dat_i[7:0]};
    // Own bit timing, restarted by each accepted write so the start bit is full length
    logic      tx_bit_end;
    wire logic tx_go = (tx_st_reg == TX_IDLE) && wr_data;
    umd_oversampler #(.DIV_W(DIV_W)) u_tx_ovs (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .divisor_i    (divisor),
        .dbl_i        (dbl),
        .line_i       (1'b1),
        .restart_i    (tx_go),
        .tick_o       (),
        .bit_end_o    (tx_bit_end),
        .vote_o       (),
        .vote_valid_o ()
    );
    wire logic       tx_end  = (tx_st_reg == TX_SHIFT) && tx_bit_end && (tx_cnt_reg == 4'h0);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_st_reg   <= TX_IDLE;
            tx_sh_reg   <= '1;
            tx_cnt_reg  <= '0;
            tx_line_reg <= 1'b1;
        end else begin
            case (tx_st_reg)
                TX_IDLE: if (wr_data) begin
                    tx_sh_reg   <= {2'b11, tx_word} | (11'h7FF << nbits);   // Unused bits become stop bits
                    tx_line_reg <= 1'b0;
                    tx_cnt_reg  <= tx_len;
                    tx_st_reg   <= TX_SHIFT;
                end
                TX_SHIFT: if (tx_bit_end) begin
                    tx_line_reg <= tx_sh_reg[0] ^ (par_en && tx_cnt_reg == tx_len - nbits - 4'h0 ? tx_par : 1'b0);
                    tx_sh_reg   <= {1'b1, tx_sh_reg[10:1]};
                    tx_cnt_reg  <= tx_cnt_reg - 4'h1;
                    if (tx_cnt_reg == 4'h0) tx_st_reg <= TX_IDLE;
                end
                default: tx_st_reg <= TX_IDLE;
            endcase
        end
    end

    // Status and control word a: set beats a write-one clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_a_reg   <= '0;
            ctrl_b_reg   <= '0;
            rx_buf_reg   <= '0;
            buf_full_reg <= 1'b0;
        end else begin
            if (wr && hit_a) begin                                        // see R16
                ctrl_a_reg[BIT_AFM] <= wb_dat_i[BIT_AFM];
                ctrl_a_reg[BIT_DSP] <= wb_dat_i[BIT_DSP];
                ctrl_a_reg[BIT_TX9] <= wb_dat_i[BIT_TX9];
                if (wb_dat_i[BIT_TXC]) ctrl_a_reg[BIT_TXC] <= 1'b0;
            end
            if (wr && hit_b) ctrl_b_reg <= wb_dat_i;
            if (tx_end) ctrl_a_reg[BIT_TXC] <= 1'b1;
            if (rd_data) begin
                buf_full_reg         <= 1'b0;
                ctrl_a_reg[BIT_RXC]  <= 1'b0;
            end
            if (store) begin
                rx_buf_reg          <= rx_word;
                buf_full_reg        <= 1'b1;
                ctrl_a_reg[BIT_RXC] <= 1'b1;
                ctrl_a_reg[BIT_FE]  <= ~vote;
                ctrl_a_reg[BIT_PE]  <= par_bad;
                ctrl_a_reg[BIT_OVR] <= buf_full_reg && !rd_data;
                ctrl_a_reg[BIT_RX9] <= nine & rx_word[8];
            end
        end
    end

    // Interrupt status: receive done, transmit done, frame error
    wire logic [NUM_EVT-1:0] evt = {store && !vote, tx_end, store};
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_reg <= '0;
            irq_mask_reg <= '0;
            irq_reg      <= 1'b0;
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~((wr && hit_i) ? wb_dat_i[NUM_EVT-1:0] : '0)) | evt;
            if (wr && hit_i) irq_mask_reg <= wb_dat_i[16 +: NUM_EVT];
            irq_reg <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    // Read mux, one-cycle ack
    wire logic [31:0] rmux = hit_a ? {23'h0, ctrl_a_reg} :
                             hit_b ? ctrl_b_reg :
                             hit_d ? {23'h0, rx_buf_reg} :
                             hit_i ? {13'h0, irq_mask_reg, 13'h0, irq_stat_reg} : 32'h0;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg  <= 1'b0;
            rdat_reg <= '0;
        end else begin
            ack_reg  <= acc;
            rdat_reg <= rd ? rmux : 32'h0;
        end
    end

    assign wb_ack_o      = ack_reg;
    assign wb_dat_o      = rdat_reg;
    assign irq_o         = irq_reg;
    assign line.s2m_line = tx_line_reg;
endmodule : umd_slave_end

/* File: umd_line_assertions.sv */
`timescale 1ns/100ps
// Watches the shared line and both user-side handshakes
module umd_line_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic m2s_line,
    input wire logic s2m_line,
    input wire logic busy_o,
    input wire logic done_o,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    line_idle_a: assert property ($fell(rst_i) |-> m2s_line && s2m_line)
        else $error("line not idle after reset");
    master_rest_a: assert property (!busy_o |-> m2s_line)
        else $error("master line low while idle");
    start_bit_a: assert property ($rose(busy_o) |-> ##[0:1] !m2s_line)
        else $error("no start bit");
    m2s_bit_len_a: assert property ($fell(m2s_line) |-> (!m2s_line) [*8])
        else $error("master low shorter than a bit");
    s2m_bit_len_a: assert property ($fell(s2m_line) |-> (!s2m_line) [*8])
        else $error("slave low shorter than a bit");
    quiet_line_a: assert property ($changed(m2s_line) |-> busy_o || $past(busy_o))
        else $error("master line moved while idle");
    done_pulse_a: assert property (done_o |=> !done_o)
        else $error("done longer than one cycle");
    done_ends_a: assert property (done_o |-> ##[0:1] !busy_o)
        else $error("busy after done");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
endmodule : umd_line_checker

/* File: uart_rx_multidrop_address_filter_test.sv */
`timescale 1ns/100ps
// Both ends across the line, slave judged against a receive model
module uart_rx_multidrop_address_filter_test;
    import umd_pkg::*;
    logic        clk_i, rst_i, dbl, send, is_addr, busy, done, cyc, stb, we, ack, irq, filt, nine;
    logic [11:0] mdiv;
    logic [7:0]  tx_data;
    logic [3:0]  adr, sel;
    logic [31:0] wdat, rdat, r, lfsr;
    logic [7:0]  exp_q[$];
    int          mismatches, n_compared, n;
    int          seq[9] = '{0, 1, 0, 1, 2, 0, 1, 3, 0};
    umd_line_if  line ();

    umd_master_end u_umd_master_end (.clk_i(clk_i), .rst_i(rst_i), .divisor_i(mdiv), .dbl_i(dbl),
        .data_i(tx_data), .is_addr_i(is_addr), .send_i(send), .busy_o(busy), .done_o(done), .line(line));
    umd_slave_end u_umd_slave_end (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat),
        .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack),
        .irq_o(irq), .line(line));
    umd_line_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .m2s_line(line.m2s_line), .s2m_line(line.s2m_line),
        .busy_o(busy), .done_o(done), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack));

    // System clock, 20 ns period
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : chk

    // Random source for the stimulus
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr_next

    task automatic tally_and_finish;
        $display("Compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish

    // Classic single Wishbone cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        int k;
        k = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hF;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack !== 1'b1);
        q = rdat;
        chk(32'(k), 32'h2, "bus ack delay");
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk_i);
    endtask : wb

    // Whole-word write of the filter and speed controls
    task automatic set_a(input logic f, input logic txc);
        filt = f;
        wb(1'b1, OFS_CTRL_A, (32'(dbl) << BIT_DSP) | (32'(f) << BIT_AFM) | (32'(txc) << BIT_TXC), r);
    endtask : set_a

    // One frame from the master, then the slave status and buffer against the model
    task automatic frame(input logic addr);
        logic [7:0] d;
        logic       keep, fe;
        int         nexp;
        lfsr = lfsr_next(lfsr);
        d = lfsr[7:0];
        keep = !filt || addr;
        fe = keep && !nine && !addr;
        if (keep) exp_q.push_back(d);
        tx_data <= d;
        is_addr <= addr;
        send <= 1'b1;
        @(posedge clk_i);
        send <= 1'b0;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (done !== 1'b1 && n < 20000);
        nexp = 12 * (dbl ? 8 : 16) * (int'(mdiv) + 1);
        chk(32'(n >= nexp && n <= nexp + 3), 32'h1, "frame time");
        wb(1'b0, OFS_CTRL_A, 32'h0, r);
        chk(32'({r[6:2], r[0]}), 32'({dbl, filt, 2'b00, fe, keep}), "status");
        if (keep) begin
            if (nine) chk(32'(r[BIT_RX9]), 32'(addr), "ninth bit");
            wb(1'b0, OFS_DATA, 32'h0, r);
            chk(32'(r[7:0]), 32'(exp_q.pop_front()), "rx data");
        end
    endtask : frame

    // Watchdog
    initial begin
        #(20 * 90000);
        mismatches++;
        tally_and_finish();
    end

    initial begin
        rst_i = 1'b1;
        {dbl, send, is_addr, cyc, stb, we, filt, nine} = 8'h00;
        {mdiv, tx_data, adr, sel, wdat, lfsr} = {12'h003, 8'h00, 4'h0, 4'h0, 32'h0, 32'h6637};
        mismatches = 0;
        n_compared = 0;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        // Normal, double speed, then eight-bit frames whose first stop bit gives the type
        for (int s = 0; s < 3; s++) begin
            dbl <= (s == 1);
            nine = (s != 2);
            @(posedge clk_i);
            wb(1'b1, OFS_CTRL_B, {4'h0, 12'h003, 13'h0, nine ? SZ_NINE : 3'h3}, r);
            set_a(1'b1, 1'b0);
            foreach (seq[i]) begin
                if (seq[i] < 2) frame(seq[i] == 1);
                else set_a(seq[i] == 3, 1'b0);
            end
        end
        // Receive event: masked, unmasked, cleared
        wb(1'b0, OFS_IRQ_STAT, 32'h0, r);
        chk(32'({r[0], irq}), 32'h2, "irq masked");
        wb(1'b1, OFS_IRQ_STAT, 32'h0001_0000, r);
        chk(32'(irq), 32'h1, "irq raised");
        wb(1'b1, OFS_IRQ_STAT, 32'h0001_0001, r);
        wb(1'b0, OFS_IRQ_STAT, 32'h0, r);
        chk(32'({r[0], irq}), 32'h0, "irq cleared");
        wb(1'b0, 4'h2, 32'h0, r);
        chk(r, 32'h0, "unmapped read");
        // Slave transmits eight bits, two stops, while filtering; line sampled mid-bit, 64 clocks a bit
        wb(1'b1, OFS_CTRL_B, 32'h0003_000B, r);
        wb(1'b1, OFS_DATA, 32'h0000_005A, r);
        repeat (94) @(posedge clk_i);
        for (int b = 0; b < 10; b++) begin
            r[b] = line.s2m_line;
            repeat (64) @(posedge clk_i);
        end
        chk(32'(r[9:0]), 32'h0000_035A, "tx frame");
        n = 0;
        do begin
            wb(1'b0, OFS_CTRL_A, 32'h0, r);
            n++;
        end while (r[BIT_TXC] !== 1'b1 && n < 2000);
        chk(32'(r[BIT_TXC]), 32'h1, "tx under filter");
        set_a(1'b1, 1'b0);
        wb(1'b0, OFS_CTRL_A, 32'h0, r);
        chk(32'({r[BIT_AFM], r[BIT_TXC]}), 32'h3, "tx flag kept");
        set_a(1'b1, 1'b1);
        wb(1'b0, OFS_CTRL_A, 32'h0, r);
        chk(32'({r[BIT_AFM], r[BIT_TXC]}), 32'h2, "tx flag cleared");
        // Master about two percent fast and slow against the slave
        nine = 1'b1;
        for (int i = 0; i < 4; i++) begin
            mdiv <= i[0] ? 12'd50 : 12'd48;
            dbl <= i[1];
            @(posedge clk_i);
            wb(1'b1, OFS_CTRL_B, {4'h0, 12'd49, 13'h0, SZ_NINE}, r);
            set_a(1'b0, 1'b0);
            frame(1'b0);
        end
        tally_and_finish();
    end
endmodule : uart_rx_multidrop_address_filter_test
